// ==== rtl/mct_timer_unit.sv ====
`timescale 1ns/10ps
module mct_timer_unit #(
  parameter mct_pkg::mct_class_e TMR_CLASS = mct_pkg::CLS_ADV,
  parameter int                  CNT_W     = 16
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Pins and debug
  input  wire logic [3:0]  chIn,
  input  wire logic        debugHalt,
  output logic      [3:0]  chOut,
  output logic      [3:0]  chOutN,
  // Timer link and DMA
  input  wire logic        linkTrigIn,
  output logic             linkTrigOut,
  output logic      [4:0]  dmaReq,
  // Interrupts
  output logic             irq,
  output logic             stkIrq
);
  import mct_pkg::*;

  localparam int NUM_CH = (TMR_CLASS == CLS_ADV || TMR_CLASS == CLS_GP4) ? 4 :
                          (TMR_CLASS == CLS_GP2) ? 2 : (TMR_CLASS == CLS_GP1) ? 1 : 0;
  localparam int NUM_COMP = (TMR_CLASS == CLS_ADV) ? 4 : (TMR_CLASS == CLS_GP2) ? 2 :
                            (TMR_CLASS == CLS_GP1) ? 1 : 0;
  localparam int EFF_W = (TMR_CLASS == CLS_BASIC || TMR_CLASS == CLS_ADV) ? 16 : CNT_W;
  localparam logic [31:0] CNT_MASK = (EFF_W == 32) ? 32'hFFFF_FFFF : 32'h0000_FFFF;
  localparam logic QUAD_OK = (TMR_CLASS == CLS_GP4);

  function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  mct_state_s s_r;
  mct_state_s s_nxt;

  logic [CH_MAX-1:0]  inSync;
  logic               freeze;
  logic               run;
  logic               cntSrc;
  logic               tick;
  logic               updEvt;
  logic               encStep;
  logic               encUp;
  logic               hallChg;
  logic [1:0]         mode;
  logic [1:0]         linkMode;
  logic [2:0]         chm;
  logic [CH_MAX-1:0]  ccSet;
  logic               stkTick;
  logic               stkZero;
  logic [ST_W-1:0]    stSet;
  logic [ST_W-1:0]    stClr;
  logic [31:0]        wd;
  logic               outGate;

  always_comb begin
    s_nxt   = s_r;
    ccSet   = '0;
    updEvt  = 1'b0;
    tick    = 1'b0;
    stkZero = 1'b0;
    stClr   = '0;
    wd      = 32'h0000_0000;

    // Two-stage pin synchronisers; only the second stage feeds logic
    s_nxt.syncA  = chIn;
    s_nxt.syncB  = s_r.syncA;
    s_nxt.inPrev = s_r.syncB;
    inSync       = s_r.syncB;

    freeze   = debugHalt & s_r.ctrl[CTRL_FREEZE];
    run      = s_r.ctrl[CTRL_EN] & ~freeze;
    linkMode = s_r.ctrl[CTRL_LINK +: 2];
    mode     = (TMR_CLASS == CLS_BASIC) ? CM_UP : s_r.ctrl[CTRL_MODE +: 2];

    // Quadrature: one count per edge of either phase
    encStep = QUAD_OK & s_r.ctrl[CTRL_ENC] &
              ((inSync[0] ^ s_r.inPrev[0]) | (inSync[1] ^ s_r.inPrev[1]));
    encUp   = ~(s_r.inPrev[0] ^ inSync[1]);
    hallChg = QUAD_OK & s_r.ctrl[CTRL_HALL] &
              ((^inSync[2:0]) ^ (^s_r.inPrev[2:0]));

    case (linkMode)
      LM_GATED:  cntSrc = linkTrigIn;
      LM_EXTCLK: cntSrc = linkTrigIn;
      default:   cntSrc = 1'b1;
    endcase

    // Prescaler: divide by psc+1
    if (run && cntSrc && !(QUAD_OK && s_r.ctrl[CTRL_ENC])) begin
      if (s_r.pscCnt >= s_r.psc) begin
        s_nxt.pscCnt = 16'h0000;
        tick         = 1'b1;
      end else begin
        s_nxt.pscCnt = s_r.pscCnt + 16'h0001;
      end
    end
    if (run && encStep) begin
      tick = 1'b1;
      mode = encUp ? CM_UP : CM_DOWN;
    end

    if (tick) begin
      case (mode)
        CM_DOWN: begin
          s_nxt.dirDown = 1'b1;
          if (s_r.cnt == 32'h0000_0000) begin
            s_nxt.cnt = s_r.arr;
            updEvt    = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - 32'h0000_0001;
          end
        end
        CM_CENTER: begin
          if (s_r.arr == 32'h0000_0000) begin
            s_nxt.cnt = 32'h0000_0000;
            updEvt    = 1'b1;
          end else if (!s_r.dirDown) begin
            if (s_r.cnt >= s_r.arr) begin
              s_nxt.dirDown = 1'b1;
              s_nxt.cnt     = s_r.arr - 32'h0000_0001;
              updEvt        = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt + 32'h0000_0001;
            end
          end else begin
            if (s_r.cnt == 32'h0000_0000) begin
              s_nxt.dirDown = 1'b0;
              s_nxt.cnt     = 32'h0000_0001;
              updEvt        = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt - 32'h0000_0001;
            end
          end
        end
        default: begin
          s_nxt.dirDown = 1'b0;
          if (s_r.cnt >= s_r.arr) begin
            s_nxt.cnt = 32'h0000_0000;
            updEvt    = 1'b1;
          end else begin
            s_nxt.cnt = (s_r.cnt + 32'h0000_0001) & CNT_MASK;
          end
        end
      endcase
    end

    // Link reset wins over counting in the same cycle
    if (run && linkMode == LM_RESET && linkTrigIn) begin
      s_nxt.cnt    = 32'h0000_0000;
      s_nxt.pscCnt = 16'h0000;
    end

    if (updEvt && s_r.ctrl[CTRL_ONEP]) begin
      s_nxt.ctrl[CTRL_EN] = 1'b0;
    end

    // Advanced outputs go inactive on halt so power stages switch off
    outGate = ~(TMR_CLASS == CLS_ADV && debugHalt);

    for (int i = 0; i < CH_MAX; i++) begin
      chm = s_r.chMode[CHM_W*i +: 3];
      if (i < NUM_CH) begin
        case (chm)
          CH_CAP_RISE, CH_CAP_FALL: begin
            if ((i == 0 && hallChg) ||
                (chm == CH_CAP_RISE && inSync[i] && !s_r.inPrev[i]) ||
                (chm == CH_CAP_FALL && !inSync[i] && s_r.inPrev[i])) begin
              s_nxt.ccr[i] = s_r.cnt;
              ccSet[i]     = 1'b1;
            end
          end
          CH_TOGGLE: begin
            if (tick && s_r.cnt == s_r.ccr[i]) begin
              s_nxt.pwmRef[i] = ~s_r.pwmRef[i];
              ccSet[i]        = 1'b1;
            end
          end
          CH_PWM: begin
            // ccr of zero holds low, ccr above arr holds high
            s_nxt.pwmRef[i] = (s_r.cnt < s_r.ccr[i]);
            ccSet[i]        = tick && (s_r.cnt == s_r.ccr[i]);
          end
          default: begin
            s_nxt.pwmRef[i] = s_r.pwmRef[i];
          end
        endcase
        // Dead-time: both legs low until the counter drains
        if (s_nxt.pwmRef[i] != s_r.pwmRef[i] && i < NUM_COMP) begin
          s_nxt.dtCnt[i] = s_r.dead;
        end else if (s_r.dtCnt[i] != 8'h00) begin
          s_nxt.dtCnt[i] = s_r.dtCnt[i] - 8'h01;
        end
        s_nxt.chOut[i]  = outGate & s_r.chMode[CHM_W*i+CHM_OEN] & s_r.pwmRef[i] &
                          (s_r.dtCnt[i] == 8'h00);
        s_nxt.chOutN[i] = (i < NUM_COMP) & outGate & s_r.chMode[CHM_W*i+CHM_OEN] &
                          ~s_r.pwmRef[i] & (s_r.dtCnt[i] == 8'h00);
      end else begin
        s_nxt.chOut[i]  = 1'b0;
        s_nxt.chOutN[i] = 1'b0;
      end
    end

    // System tick
    stkTick = 1'b0;
    if (s_r.ctrl[CTRL_STK_EN]) begin
      s_nxt.stkDiv = s_r.stkDiv + 3'h1;
      stkTick      = s_r.ctrl[CTRL_STK_DIV] ? (s_r.stkDiv == STK_DIV_LAST) : 1'b1;
    end
    if (stkTick) begin
      if (s_r.stkVal == 24'h00_0000) begin
        s_nxt.stkVal = s_r.stkLoad;
      end else begin
        s_nxt.stkVal = s_r.stkVal - 24'h00_0001;
        stkZero      = (s_r.stkVal == 24'h00_0001);
      end
    end

    stSet                  = '0;
    stSet[ST_UPD]          = updEvt;
    stSet[ST_CC +: CH_MAX] = ccSet;
    stSet[ST_STK]          = stkZero;
    stSet[ST_TRIG]         = (linkTrigIn && linkMode != LM_NONE) || hallChg;

    s_nxt.trigOut = updEvt;
    s_nxt.dmaReq  = s_r.dmaEn & {ccSet, updEvt};
    s_nxt.stkIrq  = stkZero & s_r.ctrl[CTRL_STK_INT];

    // Bus: first edge latches read data, second edge completes
    if (s_r.waitReq && (avs_read || avs_write)) begin
      s_nxt.waitReq = 1'b0;
      if (avs_read) begin
        case (avs_address)
          REG_CTRL:   s_nxt.rdData = {16'h0000, s_r.dirDown, s_r.ctrl[14:0]};
          REG_PSC:    s_nxt.rdData = {16'h0000, s_r.psc};
          REG_ARR:    s_nxt.rdData = s_r.arr;
          REG_CNT:    s_nxt.rdData = s_r.cnt;
          REG_STATUS: s_nxt.rdData = {{(32-ST_W){1'b0}}, s_r.status};
          REG_MASK:   s_nxt.rdData = {{(32-ST_W){1'b0}}, s_r.mask};
          REG_DMAEN:  s_nxt.rdData = {27'h000_0000, s_r.dmaEn};
          REG_CHMODE: s_nxt.rdData = {16'h0000, s_r.chMode};
          REG_DEAD:   s_nxt.rdData = {24'h00_0000, s_r.dead};
          REG_STKLD:  s_nxt.rdData = {8'h00, s_r.stkLoad};
          REG_STKVAL: s_nxt.rdData = {8'h00, s_r.stkVal};
          default: begin
            s_nxt.rdData = 32'h0000_0000;
            for (int i = 0; i < NUM_CH; i++) begin
              if (avs_address == REG_CCR0 + 8'(4 * i)) begin
                s_nxt.rdData = s_r.ccr[i];
              end
            end
          end
        endcase
      end
    end else if (!s_r.waitReq) begin
      s_nxt.waitReq = 1'b1;
      if (avs_read && avs_address == REG_STATUS) begin
        // Only bits that were returned are cleared
        stClr = s_r.rdData[ST_W-1:0];
      end
      if (avs_write) begin
        case (avs_address)
          REG_CTRL: begin
            wd           = beMerge({16'h0000, s_r.ctrl}, avs_writedata, avs_byteenable);
            s_nxt.ctrl   = wd[15:0] & CTRL_WMASK;
          end
          REG_PSC: begin
            wd           = beMerge({16'h0000, s_r.psc}, avs_writedata, avs_byteenable);
            s_nxt.psc    = wd[15:0];
          end
          REG_ARR:    s_nxt.arr = beMerge(s_r.arr, avs_writedata, avs_byteenable) & CNT_MASK;
          REG_CNT:    s_nxt.cnt = beMerge(s_r.cnt, avs_writedata, avs_byteenable) & CNT_MASK;
          REG_MASK: begin
            wd           = beMerge({{(32-ST_W){1'b0}}, s_r.mask}, avs_writedata, avs_byteenable);
            s_nxt.mask   = wd[ST_W-1:0];
          end
          REG_DMAEN: begin
            wd           = beMerge({27'h000_0000, s_r.dmaEn}, avs_writedata, avs_byteenable);
            s_nxt.dmaEn  = wd[4:0];
          end
          REG_CHMODE: begin
            wd           = beMerge({16'h0000, s_r.chMode}, avs_writedata, avs_byteenable);
            s_nxt.chMode = wd[15:0];
          end
          REG_DEAD: begin
            wd           = beMerge({24'h00_0000, s_r.dead}, avs_writedata, avs_byteenable);
            s_nxt.dead   = wd[7:0];
          end
          REG_STKLD: begin
            wd            = beMerge({8'h00, s_r.stkLoad}, avs_writedata, avs_byteenable);
            s_nxt.stkLoad = wd[23:0];
          end
          REG_STKVAL: begin
            // Any write clears the current value
            s_nxt.stkVal = 24'h00_0000;
          end
          default: begin
            for (int i = 0; i < NUM_CH; i++) begin
              if (avs_address == REG_CCR0 + 8'(4 * i)) begin
                s_nxt.ccr[i] = beMerge(s_r.ccr[i], avs_writedata, avs_byteenable) & CNT_MASK;
              end
            end
          end
        endcase
      end
    end

    // A new event wins over the read-clear
    s_nxt.status = (s_r.status & ~stClr) | stSet;
    s_nxt.irq    = |(s_nxt.status & s_nxt.mask);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r         <= '0;
      s_r.waitReq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata    = s_r.rdData;
  assign avs_waitrequest = s_r.waitReq;
  assign chOut           = s_r.chOut;
  assign chOutN          = s_r.chOutN;
  assign linkTrigOut     = s_r.trigOut;
  assign dmaReq          = s_r.dmaReq;
  assign irq             = s_r.irq;
  assign stkIrq          = s_r.stkIrq;

endmodule

// ==== rtl/mct_pkg.sv ====
package mct_pkg;

  // Timer classes
  typedef enum logic [2:0] {
    CLS_ADV   = 3'h0,
    CLS_GP4   = 3'h1,
    CLS_GP2   = 3'h2,
    CLS_GP1   = 3'h3,
    CLS_BASIC = 3'h4
  } mct_class_e;

  // Counting modes
  localparam logic [1:0] CM_UP     = 2'h0;
  localparam logic [1:0] CM_DOWN   = 2'h1;
  localparam logic [1:0] CM_CENTER = 2'h2;

  // Link (slave) modes
  localparam logic [1:0] LM_NONE   = 2'h0;
  localparam logic [1:0] LM_RESET  = 2'h1;
  localparam logic [1:0] LM_GATED  = 2'h2;
  localparam logic [1:0] LM_EXTCLK = 2'h3;

  // Channel modes
  localparam logic [2:0] CH_OFF      = 3'h0;
  localparam logic [2:0] CH_CAP_RISE = 3'h1;
  localparam logic [2:0] CH_CAP_FALL = 3'h2;
  localparam logic [2:0] CH_TOGGLE   = 3'h3;
  localparam logic [2:0] CH_PWM      = 3'h4;

  // Byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_PSC    = 8'h04;
  localparam logic [7:0] REG_ARR    = 8'h08;
  localparam logic [7:0] REG_CNT    = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK   = 8'h14;
  localparam logic [7:0] REG_DMAEN  = 8'h18;
  localparam logic [7:0] REG_CHMODE = 8'h1C;
  localparam logic [7:0] REG_DEAD   = 8'h20;
  localparam logic [7:0] REG_CCR0   = 8'h24;
  localparam logic [7:0] REG_STKLD  = 8'h34;
  localparam logic [7:0] REG_STKVAL = 8'h38;

  // Control bits
  localparam int CTRL_EN      = 0;
  localparam int CTRL_MODE    = 1;
  localparam int CTRL_ONEP    = 3;
  localparam int CTRL_FREEZE  = 4;
  localparam int CTRL_STK_EN  = 5;
  localparam int CTRL_STK_DIV = 6;
  localparam int CTRL_STK_INT = 7;
  localparam int CTRL_LINK    = 8;
  localparam int CTRL_ENC     = 10;
  localparam int CTRL_HALL    = 11;
  localparam int CTRL_DIR     = 15;

  // Status bits
  localparam int ST_UPD  = 0;
  localparam int ST_CC   = 1;
  localparam int ST_STK  = 5;
  localparam int ST_TRIG = 6;
  localparam int ST_W    = 7;

  localparam int CH_MAX   = 4;
  localparam int CHM_W    = 4;
  localparam int CHM_OEN  = 3;
  localparam logic [2:0] STK_DIV_LAST = 3'h7;
  localparam logic [15:0] CTRL_WMASK  = 16'h0FFF;

  typedef struct packed {
    logic                       waitReq;
    logic [31:0]                rdData;
    logic [15:0]                ctrl;
    logic [15:0]                psc;
    logic [15:0]                pscCnt;
    logic [31:0]                arr;
    logic [31:0]                cnt;
    logic                       dirDown;
    logic [ST_W-1:0]            status;
    logic [ST_W-1:0]            mask;
    logic [4:0]                 dmaEn;
    logic [15:0]                chMode;
    logic [7:0]                 dead;
    logic [CH_MAX-1:0][31:0]    ccr;
    logic [CH_MAX-1:0]          pwmRef;
    logic [CH_MAX-1:0][7:0]     dtCnt;
    logic [CH_MAX-1:0]          chOut;
    logic [CH_MAX-1:0]          chOutN;
    logic [CH_MAX-1:0]          syncA;
    logic [CH_MAX-1:0]          syncB;
    logic [CH_MAX-1:0]          inPrev;
    logic [23:0]                stkLoad;
    logic [23:0]                stkVal;
    logic [2:0]                 stkDiv;
    logic                       stkIrq;
    logic                       irq;
    logic                       trigOut;
    logic [4:0]                 dmaReq;
  } mct_state_s;

endpackage

// ==== tb/mct_timer_unit_props.sv ====
`timescale 1ns/10ps
module mct_timer_unit_props
  import mct_pkg::*;
#(
  parameter mct_class_e TMR_CLASS = CLS_ADV,
  parameter int         CNT_W     = 16
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // Avalon-MM slave
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins and debug
  input wire logic [3:0]  chIn,
  input wire logic        debugHalt,
  input wire logic [3:0]  chOut,
  input wire logic [3:0]  chOutN,
  // Link, DMA and interrupts
  input wire logic        linkTrigIn,
  input wire logic        linkTrigOut,
  input wire logic [4:0]  dmaReq,
  input wire logic        irq,
  input wire logic        stkIrq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("wait state not exactly one cycle");
  AST_WAIT_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write) && $past(avs_waitrequest))
    else $error("waitrequest low without a request");
  AST_RDATA_HOLD: assert property (!($past(avs_read) && $past(avs_waitrequest)) |-> $stable(avs_readdata))
    else $error("read data moved without a read");
  AST_RESET_VALS: assert property ($fell(sys_rst) |-> avs_waitrequest && chOut == 4'h0 && chOutN == 4'h0
    && !irq && !stkIrq && dmaReq == 5'h0 && !linkTrigOut) else $error("outputs not at rest after reset");
  AST_DEBUG_OFF: assert property ((TMR_CLASS == CLS_ADV) && debugHalt |=> chOut == 4'h0 && chOutN == 4'h0)
    else $error("outputs active during debug halt");
  AST_NO_OVERLAP: assert property ((chOut & chOutN) == 4'h0)
    else $error("main and complementary output high together");
  AST_STK_PULSE: assert property (stkIrq |=> !stkIrq)
    else $error("tick interrupt longer than one cycle");
  AST_DMA_UPD: assert property (dmaReq[0] |-> linkTrigOut)
    else $error("update request without update trigger");

  cover property (avs_read && !avs_waitrequest);
  cover property (dmaReq[0]);
  cover property (stkIrq);
  cover property (chOut[0] && !debugHalt);
endmodule

bind mct_timer_unit mct_timer_unit_props #(.TMR_CLASS(TMR_CLASS), .CNT_W(CNT_W)) props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chIn(chIn), .debugHalt(debugHalt),
  .chOut(chOut), .chOutN(chOutN), .linkTrigIn(linkTrigIn), .linkTrigOut(linkTrigOut),
  .dmaReq(dmaReq), .irq(irq), .stkIrq(stkIrq));

// ==== tb/mct_pin_model.sv ====
`timescale 1ns/10ps
module mct_pin_model (
  // Clock
  input wire logic       ref_clk,
  // Commands
  input wire logic       encStep,
  input wire logic       capPin,
  // Sensor pins
  output logic     [3:0] chIn
);
  logic [1:0] phase = 2'h0;

  // One quadrature edge per step, A leading B
  always @(posedge ref_clk) if (encStep) phase <= phase + 2'h1;
  assign chIn[0] = phase[1] ^ phase[0];
  assign chIn[1] = phase[1];
  // Hall line quiet; capture pin driven by the bench
  assign chIn[2] = 1'b0;
  assign chIn[3] = capPin;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import mct_pkg::*;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  chIn, chOut, chOutN;
  logic        debugHalt = 1'b0;
  logic        linkTrigIn = 1'b0;
  logic        encStep = 1'b0;
  logic        capPin = 1'b0;
  logic        linkTrigOut, irq, stkIrq;
  logic [4:0]  dmaReq;
  logic [31:0] q, r;
  logic [31:0] gpRdData;
  int          g, h;
  int          nErrors = 0;
  int          numChecks = 0;

  always #10 ref_clk = ~ref_clk;

  mct_pin_model far (.ref_clk(ref_clk), .encStep(encStep), .capPin(capPin), .chIn(chIn));

  mct_timer_unit #(.TMR_CLASS(CLS_ADV), .CNT_W(16)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chIn(chIn), .debugHalt(debugHalt),
    .chOut(chOut), .chOutN(chOutN), .linkTrigIn(linkTrigIn), .linkTrigOut(linkTrigOut),
    .dmaReq(dmaReq), .irq(irq), .stkIrq(stkIrq));

  // Encoder and hall decode exist only in the four-channel general-purpose class
  mct_timer_unit #(.TMR_CLASS(CLS_GP4), .CNT_W(32)) dutGp (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(gpRdData), .avs_waitrequest(), .chIn(chIn), .debugHalt(debugHalt),
    .chOut(), .chOutN(), .linkTrigIn(linkTrigIn), .linkTrigOut(),
    .dmaReq(), .irq(), .stkIrq());

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH t=%0t %s got=%0h exp=%0h", $time, msg, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", nErrors, numChecks);
    if (nErrors == 0 && numChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Request held until waitrequest is seen low; one idle edge after release
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] v);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    check(n < 100, 1'b1, "bus answer");
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h0, v);
  endtask

  // Cycles between two pulses: sel 0 update trigger, 1 tick interrupt
  task automatic gap(input int sel, output int n);
    int w;
    w = 0;
    while ((sel ? stkIrq : linkTrigOut) !== 1'b1 && w < 2000) begin
      @(posedge ref_clk);
      w++;
    end
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while ((sel ? stkIrq : linkTrigOut) !== 1'b1 && n < 2000);
  endtask

  task automatic steady(input logic o, input logic on);
    logic bad;
    bad = 1'b0;
    cyc(12);
    repeat (10) begin
      @(posedge ref_clk);
      if (chOut[0] !== o || chOutN[0] !== on) bad = 1'b1;
    end
    check(bad, 1'b0, "pwm level");
  endtask

  task automatic t_reset_unmapped;
    rd(REG_ARR, q);
    check(q, 32'h0, "arr reset");
    wr(REG_ARR, 32'h0001_0005);
    rd(REG_ARR, q);
    check(q, 32'h0000_0005, "arr 16-bit width");
    check(gpRdData, 32'h0001_0005, "arr 32-bit width");
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, q);
    check(q, 32'h0, "unmapped read");
  endtask

  task automatic t_up_irq;
    wr(REG_PSC, 32'h1);
    wr(REG_ARR, 32'h4);
    wr(REG_DMAEN, 32'h1);
    wr(REG_MASK, 32'h1);
    wr(REG_CTRL, 32'h1);
    gap(0, g);
    check(g, 32'hA, "up period");
    wr(REG_CTRL, 32'h0);
    cyc(3);
    check(irq, 1'b1, "irq set");
    rd(REG_STATUS, q);
    check(q & 32'h1, 32'h1, "update flag");
    cyc(2);
    check(irq, 1'b0, "irq cleared by read");
    rd(REG_STATUS, q);
    check(q, 32'h0, "status cleared");
  endtask

  task automatic t_down_center;
    wr(REG_MASK, 32'h0);
    wr(REG_CTRL, 32'h3);
    gap(0, g);
    check(g, 32'hA, "down period");
    rd(REG_CTRL, q);
    check(q & 32'h8000, 32'h8000, "down direction");
    check(irq, 1'b0, "masked irq");
    wr(REG_PSC, 32'h0);
    wr(REG_CTRL, 32'h5);
    // Skip a pulse still left over from down counting
    cyc(1);
    gap(0, g);
    check(g, 32'h4, "center half period");
    gap(0, g);
    check(g, 32'h4, "center half period");
  endtask

  task automatic t_pwm_debug;
    wr(REG_ARR, 32'h9);
    wr(REG_CHMODE, 32'hC);
    wr(REG_DEAD, 32'h2);
    wr(REG_CCR0, 32'h0);
    wr(REG_CTRL, 32'h1);
    steady(1'b0, 1'b1);
    wr(REG_CCR0, 32'hA);
    steady(1'b1, 1'b0);
    wr(REG_CCR0, 32'h5);
    cyc(12);
    g = 0;
    h = 0;
    repeat (10) begin
      @(posedge ref_clk);
      g += int'(chOut[0] === 1'b1);
      h += int'(chOutN[0] === 1'b1);
    end
    // Five reference cycles per leg, each shortened by two dead cycles
    check(g, 32'h3, "half duty");
    check(h, 32'h3, "half duty complement");
    wr(REG_CTRL, 32'h11);
    debugHalt <= 1'b1;
    cyc(3);
    check({chOut, chOutN}, 8'h00, "outputs off in debug");
    rd(REG_CNT, q);
    cyc(5);
    rd(REG_CNT, r);
    check(r, q, "counter frozen");
    debugHalt <= 1'b0;
  endtask

  task automatic t_link;
    wr(REG_CHMODE, 32'h0);
    wr(REG_CTRL, 32'h201);
    rd(REG_CNT, q);
    cyc(5);
    rd(REG_CNT, r);
    check(r, q, "gated hold");
    linkTrigIn <= 1'b1;
    cyc(5);
    rd(REG_CNT, r);
    check(r !== q, 1'b1, "gated run");
    wr(REG_CTRL, 32'h101);
    rd(REG_CNT, r);
    check(r, 32'h0, "held in link reset");
    linkTrigIn <= 1'b0;
    wr(REG_CTRL, 32'h9);
    cyc(20);
    rd(REG_CTRL, q);
    check(q & 32'h1, 32'h0, "single pulse stops counter");
  endtask

  task automatic t_enc_cap;
    wr(REG_CTRL, 32'h0);
    wr(REG_ARR, 32'hFF);
    wr(REG_CNT, 32'h0);
    wr(REG_CTRL, 32'hC01);
    rd(REG_STATUS, q);
    repeat (4) begin
      encStep <= 1'b1;
      @(posedge ref_clk);
      encStep <= 1'b0;
      cyc(4);
    end
    cyc(5);
    rd(REG_CNT, q);
    check(gpRdData, 32'h4, "encoder count");
    rd(REG_STATUS, q);
    check(gpRdData & 32'h40, 32'h40, "hall change flag");
    wr(REG_CTRL, 32'h0);
    wr(REG_CHMODE, 32'h1000);
    wr(REG_CTRL, 32'h1);
    rd(REG_STATUS, q);
    capPin <= 1'b1;
    cyc(6);
    rd(REG_STATUS, q);
    check(q & 32'h10, 32'h10, "capture flag");
    wr(REG_CTRL, 32'h0);
  endtask

  task automatic t_tick;
    wr(REG_STKLD, 32'h3);
    wr(REG_STKVAL, 32'h0);
    wr(REG_CTRL, 32'hA0);
    gap(1, g);
    check(g, 32'h4, "tick period");
    wr(REG_CTRL, 32'hE0);
    gap(1, g);
    gap(1, g);
    check(g, 32'h20, "tick period div8");
    wr(REG_CTRL, 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    nErrors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    cyc(4);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset_unmapped();
    t_up_irq();
    t_down_center();
    t_pwm_debug();
    t_link();
    t_enc_cap();
    t_tick();
    tally_and_finish();
  end
endmodule
